// ---- rtl/mcs_pkg.sv ----
// memory control settings: offsets, field layout, reset values, counts
// assumes a 32-bit configuration access port on the memory controller clock
package mcs_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] MCS_SETTINGS_OFFSET = 8'h40;
  localparam logic [31:0] MCS_SETTINGS_RESET = 32'h0000_0000;

  // field positions
  localparam int MCS_FSM_EN_BIT = 20;
  localparam int MCS_ELECTRICAL_THROTTLE_WINDOW_SEL_LSB = 18;
  localparam int MCS_GLOBAL_WINDOW_MODE_BIT = 17;
  localparam int MCS_MIRROR_BIT = 16;
  localparam int MCS_SCRUB_ALGO_BIT = 8;
  localparam int MCS_PATROL_EN_BIT = 7;
  localparam int MCS_DEMAND_EN_BIT = 6;
  localparam int MCS_NB_CHECK_BIT = 5;
  localparam int MCS_SCRUB_DONE_BIT = 4;

  // byte lanes holding the implemented fields
  localparam int MCS_LANE_HI = 2;
  localparam int MCS_LANE_MID = 1;
  localparam int MCS_LANE_LO = 0;

  // ----------------------------------------------------------------------
  // electrical throttle
  // ----------------------------------------------------------------------
  localparam logic [4:0] MCS_ETW_CLK_SEL0 = 5'h0A;
  localparam logic [4:0] MCS_ETW_CLK_SEL1 = 5'h0D;
  localparam logic [4:0] MCS_ETW_CLK_SEL2 = 5'h0F;
  localparam logic [4:0] MCS_ETW_CLK_SEL3 = 5'h14;
  localparam logic [2:0] MCS_ETW_MAX_ACTS = 3'h4;

  // ----------------------------------------------------------------------
  // global throttle
  // ----------------------------------------------------------------------
  localparam int unsigned MCS_GW_UNIT = 1344;
  localparam int unsigned MCS_GW_NORMAL_MULT = 16384;
  localparam int unsigned MCS_GW_DEBUG_MULT = 4;
  localparam int unsigned MCS_GW_NORMAL_CYCLES =
    MCS_GW_NORMAL_MULT * MCS_GW_UNIT;
  localparam int unsigned MCS_GW_DEBUG_CYCLES =
    MCS_GW_DEBUG_MULT * MCS_GW_UNIT;
  localparam logic [4:0] MCS_GW_HOLD_NORMAL = 5'h10;
  localparam logic [4:0] MCS_GW_HOLD_DEBUG = 5'h02;
  localparam logic [7:0] MCS_GW_LIMIT_CAP = 8'hA8;
  localparam int MCS_GW_GRAN_SHIFT_NORMAL = 16;
  localparam int MCS_GW_GRAN_SHIFT_DEBUG = 4;

  // ----------------------------------------------------------------------
  // patrol scrub
  // ----------------------------------------------------------------------
  typedef enum logic {MCS_SCRUB_IDLE, MCS_SCRUB_RUN} mcs_scrub_state_type;

endpackage

// ---- rtl/mcs_act_if.sv ----
// activate request and grant carried between the settings block and
// its two throttle units; all on the memory controller clock
`timescale 1ns/1ps
interface mcs_act_if #(parameter int RANKS = 8);
  logic [RANKS-1:0] act_req;
  logic [RANKS-1:0] act_grant;
  logic run;

  modport ctrl (output act_req, output run, input act_grant);
  modport elec (input act_req, input run, output act_grant);
  modport glob (input act_grant);
endinterface

// ---- rtl/mcs_electrical_throttle_window_sel.sv ----
// per-rank electrical activate throttle over a short window
// assumes one activate request per rank per cycle from the scheduler
`timescale 1ns/1ps
module mcs_electrical_throttle_window_sel #(
  parameter int RANKS = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] window_sel,
  input wire logic [RANKS-1:0] throttle_en,
  mcs_act_if.elec act
);
  import mcs_pkg::*;

  // ----------------------------------------------------------------------
  // window timer
  // ----------------------------------------------------------------------
  logic [4:0] win_cnt;
  logic [4:0] win_len;
  logic boundary;

  assign win_len = (window_sel == 2'h0) ? MCS_ETW_CLK_SEL0 :
                   (window_sel == 2'h1) ? MCS_ETW_CLK_SEL1 :
                   (window_sel == 2'h2) ? MCS_ETW_CLK_SEL2 :
                   MCS_ETW_CLK_SEL3;
  // >= keeps a shortened window from running past its new end
  assign boundary = win_cnt >= (win_len - 5'h01);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      win_cnt <= 5'h00;
    end else if (boundary) begin
      win_cnt <= 5'h00;
    end else begin
      win_cnt <= win_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // per-rank activate counters
  // ----------------------------------------------------------------------
  for (genvar r = 0; r < RANKS; r++) begin : g_rank
    logic [2:0] acts;
    logic allow;

    assign allow = !throttle_en[r] || (acts < MCS_ETW_MAX_ACTS);
    assign act.act_grant[r] = act.run && act.act_req[r] && allow;

    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        acts <= 3'h0;
      end else if (boundary) begin
        acts <= 3'h0;
      end else if (act.act_grant[r] && acts < MCS_ETW_MAX_ACTS) begin
        acts <= acts + 3'h1;
      end
    end
  end

endmodule

// ---- rtl/mcs_gthrot.sv ----
// global activate window: counts granted activates and raises the
// throttle status; the limit comes from the separate limit register
`timescale 1ns/1ps
module mcs_gthrot #(
  parameter int RANKS = 8,
  parameter int unsigned NORMAL_CYCLES = mcs_pkg::MCS_GW_NORMAL_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic window_mode,
  input wire logic [7:0] global_activation_limit,
  mcs_act_if.glob act,
  output logic global_throttle_status
);
  import mcs_pkg::*;

  logic [31:0] win_cnt;
  logic [31:0] win_last;
  logic win_end;
  logic [31:0] act_cnt;
  logic [31:0] acts_now;
  logic [31:0] act_sum;
  logic [7:0] cap;
  logic [31:0] thresh;
  logic over_now;
  logic win_over;
  logic [4:0] quiet;
  logic [4:0] hold;

  // ----------------------------------------------------------------------
  // window and count
  // ----------------------------------------------------------------------
  assign win_last = window_mode ? 32'(MCS_GW_DEBUG_CYCLES - 1) :
                    32'(NORMAL_CYCLES - 1);
  assign win_end = win_cnt >= win_last;
  assign acts_now = 32'($countones(act.act_grant));
  assign act_sum = act_cnt + acts_now;
  // limits above the cap behave as the cap
  assign cap = (global_activation_limit > MCS_GW_LIMIT_CAP) ?
               MCS_GW_LIMIT_CAP : global_activation_limit;
  assign thresh = window_mode ?
                  (32'(cap) << MCS_GW_GRAN_SHIFT_DEBUG) :
                  (32'(cap) << MCS_GW_GRAN_SHIFT_NORMAL);
  assign over_now = (cap != 8'h00) && (act_sum > thresh);
  assign hold = window_mode ? MCS_GW_HOLD_DEBUG : MCS_GW_HOLD_NORMAL;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      win_cnt <= 32'h0000_0000;
      act_cnt <= 32'h0000_0000;
      win_over <= 1'b0;
    end else if (win_end) begin
      win_cnt <= 32'h0000_0000;
      act_cnt <= 32'h0000_0000;
      win_over <= 1'b0;
    end else begin
      win_cnt <= win_cnt + 32'h0000_0001;
      act_cnt <= act_sum;
      win_over <= win_over || over_now;
    end
  end

  // ----------------------------------------------------------------------
  // throttle state
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      global_throttle_status <= 1'b0;
      quiet <= 5'h00;
    end else if (over_now) begin
      global_throttle_status <= 1'b1;
      quiet <= 5'h00;
    end else if (win_end && global_throttle_status) begin
      if (win_over) begin
        quiet <= 5'h00;
      end else if (quiet + 5'h01 >= hold) begin
        global_throttle_status <= 1'b0;
        quiet <= 5'h00;
      end else begin
        quiet <= quiet + 5'h01;
      end
    end
  end

endmodule

// ---- rtl/mcs_top.sv ----
// memory control settings register and the logic it steers
// assumes a 32-bit configuration port, one clock, same-clock inputs
`timescale 1ns/1ps
module mcs_top #(
  parameter int RANKS = 8,
  parameter int ADDR_W = 32,
  parameter int unsigned GW_NORMAL_CYCLES = mcs_pkg::MCS_GW_NORMAL_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic system_reset_register,
  input wire logic config_save_bit,
  output logic cmd_state_machine_enable,
  output logic cmd_fsm_sync_reset,
  input wire logic [RANKS-1:0] act_req,
  output logic [RANKS-1:0] act_grant,
  input wire logic [RANKS-1:0] dimm_electrical_throttle_enable,
  input wire logic [7:0] global_activation_limit,
  output logic global_throttle_status,
  output logic mirror_enable,
  output logic scrub_algorithm_sel,
  output logic demand_scrub_enable,
  output logic northbound_check_enable,
  input wire logic [ADDR_W-1:0] scrub_last_addr,
  output logic scrub_req,
  output logic [ADDR_W-1:0] scrub_addr,
  input wire logic scrub_ack,
  output logic scrub_complete
);
  import mcs_pkg::*;

  // ----------------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------------
  logic [1:0] electrical_throttle_window_sel;
  logic global_window_mode;
  logic patrol_scrub_enable;
  logic patrol_prev;
  mcs_scrub_state_type scrub_state;
  mcs_scrub_state_type next_scrub_state;
  logic [ADDR_W-1:0] next_scrub_addr;

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  logic hit;
  logic wr_hi;
  logic wr_mid;
  logic wr_lo;
  logic fsm_written_one;
  logic done_clear;
  logic done_set;
  logic scrub_start;
  logic scrub_abort;
  logic scrub_last;
  logic save_reset;
  logic full_reset;
  logic [31:0] image;

  assign hit = cfg_addr == MCS_SETTINGS_OFFSET;
  assign wr_hi = cfg_wr && hit && cfg_be[MCS_LANE_HI];
  assign wr_mid = cfg_wr && hit && cfg_be[MCS_LANE_MID];
  assign wr_lo = cfg_wr && hit && cfg_be[MCS_LANE_LO];
  assign fsm_written_one = wr_hi && cfg_wdata[MCS_FSM_EN_BIT];
  assign done_clear = wr_lo && cfg_wdata[MCS_SCRUB_DONE_BIT];
  // system reset with save: only the enable bit falls back
  assign save_reset = system_reset_register && config_save_bit;
  assign full_reset = system_reset_register && !config_save_bit;

  assign image = {11'h000,
                  cmd_state_machine_enable,
                  electrical_throttle_window_sel,
                  global_window_mode,
                  mirror_enable,
                  7'h00,
                  scrub_algorithm_sel,
                  patrol_scrub_enable,
                  demand_scrub_enable,
                  northbound_check_enable,
                  scrub_complete,
                  4'h0};

  // ----------------------------------------------------------------------
  // command state machine enable
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_state_machine_enable <= MCS_SETTINGS_RESET[MCS_FSM_EN_BIT];
      cmd_fsm_sync_reset <= 1'b0;
    end else if (save_reset || full_reset) begin
      cmd_state_machine_enable <= MCS_SETTINGS_RESET[MCS_FSM_EN_BIT];
      cmd_fsm_sync_reset <= 1'b0;
    end else begin
      if (wr_hi) begin
        cmd_state_machine_enable <= cfg_wdata[MCS_FSM_EN_BIT];
      end
      // every write of one restarts the command machine cleanly, unless a system reset lands on the same edge
      cmd_fsm_sync_reset <= fsm_written_one;
    end
  end

  // ----------------------------------------------------------------------
  // steering fields
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      electrical_throttle_window_sel <=
        MCS_SETTINGS_RESET[MCS_ELECTRICAL_THROTTLE_WINDOW_SEL_LSB +: 2];
      global_window_mode <= MCS_SETTINGS_RESET[MCS_GLOBAL_WINDOW_MODE_BIT];
      mirror_enable <= MCS_SETTINGS_RESET[MCS_MIRROR_BIT];
    end else if (full_reset) begin
      electrical_throttle_window_sel <=
        MCS_SETTINGS_RESET[MCS_ELECTRICAL_THROTTLE_WINDOW_SEL_LSB +: 2];
      global_window_mode <= MCS_SETTINGS_RESET[MCS_GLOBAL_WINDOW_MODE_BIT];
      mirror_enable <= MCS_SETTINGS_RESET[MCS_MIRROR_BIT];
    end else if (wr_hi) begin
      electrical_throttle_window_sel <=
        cfg_wdata[MCS_ELECTRICAL_THROTTLE_WINDOW_SEL_LSB +: 2];
      global_window_mode <= cfg_wdata[MCS_GLOBAL_WINDOW_MODE_BIT];
      // legality against sparing and interleave ways is software's job
      mirror_enable <= cfg_wdata[MCS_MIRROR_BIT];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scrub_algorithm_sel <= MCS_SETTINGS_RESET[MCS_SCRUB_ALGO_BIT];
    end else if (full_reset) begin
      scrub_algorithm_sel <= MCS_SETTINGS_RESET[MCS_SCRUB_ALGO_BIT];
    end else if (wr_mid) begin
      scrub_algorithm_sel <= cfg_wdata[MCS_SCRUB_ALGO_BIT];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      patrol_scrub_enable <= MCS_SETTINGS_RESET[MCS_PATROL_EN_BIT];
      demand_scrub_enable <= MCS_SETTINGS_RESET[MCS_DEMAND_EN_BIT];
      northbound_check_enable <= MCS_SETTINGS_RESET[MCS_NB_CHECK_BIT];
    end else if (full_reset) begin
      patrol_scrub_enable <= MCS_SETTINGS_RESET[MCS_PATROL_EN_BIT];
      demand_scrub_enable <= MCS_SETTINGS_RESET[MCS_DEMAND_EN_BIT];
      northbound_check_enable <= MCS_SETTINGS_RESET[MCS_NB_CHECK_BIT];
    end else if (wr_lo) begin
      patrol_scrub_enable <= cfg_wdata[MCS_PATROL_EN_BIT];
      demand_scrub_enable <= cfg_wdata[MCS_DEMAND_EN_BIT];
      // one enable gates crc/ecc, alerts, status packets, logging, poison
      northbound_check_enable <= cfg_wdata[MCS_NB_CHECK_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // patrol scrub walker
  // ----------------------------------------------------------------------
  assign scrub_start = patrol_scrub_enable && !patrol_prev;
  assign scrub_abort = !patrol_scrub_enable;
  assign scrub_last = scrub_addr == scrub_last_addr;
  // reads are withheld with the command machine, so the pass just pauses
  assign scrub_req = (scrub_state == MCS_SCRUB_RUN) &&
                     patrol_scrub_enable && cmd_state_machine_enable;
  assign done_set = scrub_req && scrub_ack && scrub_last;

  always_comb begin
    next_scrub_state = scrub_state;
    next_scrub_addr = scrub_addr;
    unique case (scrub_state)
      MCS_SCRUB_IDLE: begin
        if (scrub_start) begin
          next_scrub_state = MCS_SCRUB_RUN;
          next_scrub_addr = '0;
        end
      end
      MCS_SCRUB_RUN: begin
        if (scrub_abort) begin
          next_scrub_state = MCS_SCRUB_IDLE;
        end else if (scrub_req && scrub_ack) begin
          if (scrub_last) begin
            next_scrub_state = MCS_SCRUB_IDLE;
          end else begin
            next_scrub_addr = scrub_addr + ADDR_W'(1);
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scrub_state <= MCS_SCRUB_IDLE;
      scrub_addr <= '0;
      patrol_prev <= 1'b0;
    end else begin
      scrub_state <= next_scrub_state;
      scrub_addr <= next_scrub_addr;
      patrol_prev <= patrol_scrub_enable;
    end
  end

  // set beats a same-cycle write-one clear so no pass end is lost
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scrub_complete <= MCS_SETTINGS_RESET[MCS_SCRUB_DONE_BIT];
    end else if (done_set) begin
      scrub_complete <= 1'b1;
    end else if (done_clear || full_reset) begin
      scrub_complete <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata <= hit ? image : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // activate throttling
  // ----------------------------------------------------------------------
  mcs_act_if #(.RANKS(RANKS)) act_bus ();

  assign act_bus.act_req = act_req;
  assign act_bus.run = cmd_state_machine_enable;
  assign act_grant = act_bus.act_grant;

  mcs_electrical_throttle_window_sel #(.RANKS(RANKS)) u_electrical_throttle_window_sel (
    .clock(clock),
    .nrst(nrst),
    .window_sel(electrical_throttle_window_sel),
    .throttle_en(dimm_electrical_throttle_enable),
    .act(act_bus.elec)
  );

  mcs_gthrot #(.RANKS(RANKS), .NORMAL_CYCLES(GW_NORMAL_CYCLES)) u_gthrot (
    .clock(clock),
    .nrst(nrst),
    .window_mode(global_window_mode),
    .global_activation_limit(global_activation_limit),
    .act(act_bus.glob),
    .global_throttle_status(global_throttle_status)
  );

endmodule

// ---- sim/mcs_monitor.sv ----
// port checker for the memory control settings block
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module mcs_monitor #(
  parameter int RANKS = 8,
  parameter int ADDR_W = 32,
  parameter int unsigned GW_NORMAL_CYCLES = mcs_pkg::MCS_GW_NORMAL_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic system_reset_register,
  input wire logic cmd_state_machine_enable,
  input wire logic cmd_fsm_sync_reset,
  input wire logic [RANKS-1:0] act_req,
  input wire logic [RANKS-1:0] act_grant,
  input wire logic [RANKS-1:0] dimm_electrical_throttle_enable,
  input wire logic [7:0] global_activation_limit,
  input wire logic global_throttle_status,
  input wire logic mirror_enable,
  input wire logic scrub_algorithm_sel,
  input wire logic demand_scrub_enable,
  input wire logic northbound_check_enable,
  input wire logic [ADDR_W-1:0] scrub_last_addr,
  input wire logic scrub_req,
  input wire logic [ADDR_W-1:0] scrub_addr,
  input wire logic scrub_ack,
  input wire logic scrub_complete
);
  import mcs_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic wr40;
  logic hit;
  logic last_ack;
  assign wr40 = cfg_wr && cfg_addr == MCS_SETTINGS_OFFSET;
  // a system reset on the same edge has its own priority, so skip it
  assign hit = wr40 && !system_reset_register;
  assign last_ack = scrub_req && scrub_ack && scrub_addr == scrub_last_addr;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_en_write;
    wr40 && cfg_be[2] && cfg_wdata[20];
  endsequence
  sequence s_pulse;
    cmd_fsm_sync_reset && cmd_state_machine_enable;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_enable_write: assert property (
    hit && cfg_be[2] |=> cmd_state_machine_enable == $past(cfg_wdata[20]))
    else $error("enable bit differs from written value");
  chk_sync_pulse: assert property (hit ##0 s_en_write |=> s_pulse)
    else $error("no sync reset pulse after enable write");
  chk_pulse_cause: assert property (
    !(wr40 && cfg_be[2] && cfg_wdata[20]) |=> !cmd_fsm_sync_reset)
    else $error("sync reset pulse without enable write");
  chk_halt_disabled: assert property (
    !cmd_state_machine_enable && !$past(cmd_state_machine_enable)
    |-> act_grant == '0 && !scrub_req)
    else $error("activity while command machine disabled");
  chk_sysrst_clear: assert property (
    system_reset_register && !cfg_wr |=> !cmd_state_machine_enable)
    else $error("enable bit kept across system reset");
  chk_grant_unthrottled: assert property (
    cmd_state_machine_enable && $past(cmd_state_machine_enable)
    && !cmd_fsm_sync_reset
    |-> &(act_grant | dimm_electrical_throttle_enable | ~act_req))
    else $error("unthrottled rank refused");
  chk_mirror_write: assert property (
    hit && cfg_be[2] |=> mirror_enable == $past(cfg_wdata[16]))
    else $error("mirror bit differs from written value");
  chk_algo_write: assert property (
    hit && cfg_be[1] |=> scrub_algorithm_sel == $past(cfg_wdata[8]))
    else $error("scrub algorithm bit differs");
  chk_lane_low: assert property (
    hit && cfg_be[0] |=> demand_scrub_enable == $past(cfg_wdata[6])
    && northbound_check_enable == $past(cfg_wdata[5]))
    else $error("demand or check enable differs");
  chk_scrub_advance: assert property (
    scrub_req && scrub_ack && !last_ack && !cfg_wr && !system_reset_register
    |=> scrub_addr == $past(scrub_addr) + 1'b1)
    else $error("scrub address did not step");
  chk_done_set: assert property (
    last_ack && !system_reset_register |=> scrub_complete)
    else $error("complete not set after last line");
  chk_done_cause: assert property (
    $rose(scrub_complete) |-> $past(last_ack))
    else $error("complete set without finished pass");
  chk_limit_zero: assert property (
    global_activation_limit == 8'h00 && !global_throttle_status
    |=> !global_throttle_status)
    else $error("throttle started with zero limit");
endmodule

// ---- sim/mcs_scrub_mem.sv ----
// memory-side model answering scrub line requests
// assumes requests settle before the falling edge
`timescale 1ns/1ps
module mcs_scrub_mem (
  input wire logic clock,
  input wire logic nrst,
  input wire logic scrub_req,
  input wire logic slow,
  output logic scrub_ack
);
  // ----------------------------------------------------------------
  // line service
  // ----------------------------------------------------------------
  // a slow channel answers about one line in four, so a pass can be
  // caught midway and aborted
  always @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      scrub_ack <= 1'b0;
    end else begin
      scrub_ack <= scrub_req && (!slow || $urandom_range(3) == 0);
    end
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the memory control settings block
// assumes the scrub memory model and the port checker bound to the top
`timescale 1ns/1ps
module testbench;
  import mcs_pkg::*;
  logic clock, nrst, cfg_wr, cfg_rd, system_reset_register, config_save_bit;
  logic cmd_state_machine_enable, cmd_fsm_sync_reset, global_throttle_status;
  logic mirror_enable, scrub_algorithm_sel, demand_scrub_enable;
  logic northbound_check_enable, scrub_req, scrub_ack, scrub_complete;
  logic slow, rd_d;
  logic [7:0] cfg_addr, global_activation_limit;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, img, scrub_last_addr, scrub_addr;
  logic [7:0] act_req, act_grant, dimm_electrical_throttle_enable;
  logic [31:0] expq[$];
  int bad_count, total_checks, n, k, a, b;
  int lens[4] = '{10, 13, 15, 20};
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  mcs_top #(.GW_NORMAL_CYCLES(64)) dut (.*);
  mcs_scrub_mem mem (.clock(clock), .nrst(nrst), .scrub_req(scrub_req),
    .slow(slow), .scrub_ack(scrub_ack));
  always #2.5 clock = ~clock;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tmo(int c, int lim);
    if (c >= lim) begin
      bad_count++;
      $display("ERROR wait expected done seen timeout");
      test_done();
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [3:0] be, logic [31:0] d);
    @(negedge clock);
    cfg_wr = 1'b1;
    cfg_addr = ad;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [31:0] e);
    @(negedge clock);
    cfg_rd = 1'b1;
    cfg_addr = ad;
    expq.push_back(e);
    @(negedge clock);
    cfg_rd = 1'b0;
  endtask
  task automatic sysrst(logic keep);
    @(negedge clock);
    config_save_bit = keep;
    system_reset_register = 1'b1;
    @(negedge clock);
    system_reset_register = 1'b0;
  endtask
  // counts falling edges while rank 0 grant holds the given level
  task automatic span(logic v, output int c);
    c = 0;
    while (act_grant[0] === v && c < 40) begin
      @(negedge clock);
      c++;
    end
    tmo(c, 40);
  endtask
  // read data answers one cycle after the strobe; oldest note first
  always @(posedge clock) rd_d <= cfg_rd;
  always @(negedge clock) begin
    if (rd_d) begin
      chk("read data", expq.pop_front(), cfg_rdata);
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock, nrst, cfg_wr, cfg_rd, system_reset_register} = '0;
    {config_save_bit, slow, cfg_addr, cfg_be, cfg_wdata, act_req} = '0;
    {dimm_electrical_throttle_enable, global_activation_limit} = '0;
    scrub_last_addr = 32'h0000_0005;
    bad_count = 0;
    total_checks = 0;
    k = $urandom(32'hA20B);
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    rd(8'h40, 32'h0);
    wr(8'h44, 4'hF, 32'h0010_0000);
    rd(8'h44, 32'h0);
    rd(8'h40, 32'h0);
    for (k = 0; k < 6; k++) begin
      img = $urandom & 32'h001F_0160;
      if (img[16]) img[6] = 1'b0;
      wr(8'h40, 4'hF, img | ($urandom & 32'hFFE0_FE0F));
      rd(8'h40, img);
    end
    wr(8'h40, 4'h4, 32'h0);
    rd(8'h40, img & 32'h0000_FFFF);
    wr(8'h40, 4'hF, 32'h001F_0160);
    sysrst(1'b1);
    rd(8'h40, 32'h000F_0160);
    sysrst(1'b0);
    rd(8'h40, 32'h0);
    act_req = 8'h03;
    dimm_electrical_throttle_enable = 8'h01;
    repeat (3) @(negedge clock);
    chk("grant disabled", 32'h0, {24'h0, act_grant});
    for (k = 0; k < 4; k++) begin
      wr(8'h40, 4'h4, 32'h0010_0000 | (32'(k) << 18));
      repeat (25) @(negedge clock);
      span(1'b1, n);
      span(1'b0, n);
      span(1'b1, a);
      span(1'b0, b);
      chk("grants per window", 32'd4, 32'(a));
      chk("window length", 32'(lens[k]), 32'(a + b));
      chk("unthrottled rank", 32'h1, {31'h0, act_grant[1]});
    end
    dimm_electrical_throttle_enable = 8'h00;
    act_req = 8'h02;
    global_activation_limit = 8'h01;
    wr(8'h40, 4'h4, 32'h0012_0000);
    for (n = 0; n < 6000 && !global_throttle_status; n++) @(negedge clock);
    chk("throttle start", 32'h1, {31'h0, global_throttle_status});
    act_req = 8'h00;
    for (n = 0; n < 17000 && global_throttle_status; n++) @(negedge clock);
    chk("release span", 32'h1, {31'h0, n > 10752 && n <= 16130});
    wr(8'h40, 4'h1, 32'h0000_0080);
    for (n = 0; n < 10 && !scrub_req; n++) @(negedge clock);
    tmo(n, 10);
    chk("first line", 32'h0, scrub_addr);
    for (n = 0; n < 100 && !scrub_complete; n++) @(negedge clock);
    tmo(n, 100);
    rd(8'h40, 32'h0012_0090);
    wr(8'h40, 4'h1, 32'h0000_0010);
    rd(8'h40, 32'h0012_0000);
    slow = 1'b1;
    scrub_last_addr = 32'h0000_0040;
    wr(8'h40, 4'h1, 32'h0000_0080);
    repeat (12) @(negedge clock);
    wr(8'h40, 4'h1, 32'h0000_0000);
    repeat (100) @(negedge clock);
    chk("aborted pass", 32'h0, {31'h0, scrub_complete});
    scrub_last_addr = 32'h0000_0005;
    wr(8'h40, 4'h1, 32'h0000_0080);
    for (n = 0; n < 10 && !scrub_req; n++) @(negedge clock);
    tmo(n, 10);
    chk("restart line", 32'h0, scrub_addr);
    for (n = 0; n < 300 && !scrub_complete; n++) @(negedge clock);
    tmo(n, 300);
    test_done();
  end
endmodule
bind mcs_top mcs_monitor #(.RANKS(RANKS), .ADDR_W(ADDR_W),
  .GW_NORMAL_CYCLES(GW_NORMAL_CYCLES)) mon (.*);
